//--- rtl/sorc_top.sv
// starter overload-relay control: host control decode, status and trip logic
`default_nettype none
// Operation
// - current byte 2, percent 0..255
// - current is max phase over setting
// - thermal image in byte 3
// - overload trips at 110 percent
// - phase fault trips at 100 percent
// - unbalance trip lifts image to 110
// - relay trip restart only below 100
// - run bit; falling edge acknowledges fault
// - remote trip rising edge stops, code 6
// - remote trip is external fault, stop
// - remote trip only profiles 1..9
// - relay enabled: starter stops at 110
// - relay needs selector in automatic
// - disabled mid-trip: trip stays, code 5
// - relay off on link fail or running
// - relay enable must be refreshed each cycle
// - relay controls only profiles 1..9
// - mode bit: manual ack or auto restart
// - ack request at 110 in manual
// - code 5 while image at least 110
// - mode to automatic clears ack request
// - code 5 clears below 100
// - no ack request in automatic
module sorc_top #(
    parameter int CUR_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] hostControl,
    input wire logic hostStrobe,
    input wire logic [3:0] profileSelect,
    input wire logic selectorAuto,
    input wire logic breakerLinkOk,
    input wire logic phaseUnbalance,
    input wire logic [7:0] thermalImage,
    input wire sorc_pkg::sorc_phase_t phaseCurrents,
    input wire logic [CUR_W-1:0] releaseSetting,
    input wire logic [1:0] readOffset,
    input wire logic starterStopped,
    output logic [7:0] readData,
    output logic [7:0] statusByte,
    output logic [7:0] relativeCurrent,
    output logic [7:0] thermalImageOut,
    output logic starterRun,
    output logic externalFault,
    output logic breakerTripReq,
    output logic breakerRelayEnable
);
    sorc_pkg::sorc_ctrl_t ctrl;
    logic remoteTripRise;
    logic runFall;
    logic modeRise;
    logic cycleTick;
    logic [7:0] relCur;

    // ----------------------------------------
    // submodules
    // ----------------------------------------
    sorc_ctrl_decode u_decode (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .hostControl(hostControl),
        .hostStrobe(hostStrobe),
        .ctrl(ctrl),
        .remoteTripRise(remoteTripRise),
        .runFall(runFall),
        .modeRise(modeRise),
        .cycleTick(cycleTick)
    );

    sorc_rel_current #(.W(CUR_W)) u_current (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .phases(phaseCurrents),
        .releaseSetting(releaseSetting),
        .relativeCurrent(relCur)
    );

    function automatic logic atLeast(input logic [7:0] v, input logic [7:0] lim);
        atLeast = (v >= lim);
    endfunction

    // ----------------------------------------
    // trip state
    // ----------------------------------------
    logic breakerProfile;
    logic relayActive;
    logic thHigh;
    logic thLow;
    logic relayTrip_reg;
    logic relayTrip_next;
    logic remoteTrip_reg;
    logic remoteTrip_next;
    logic ackReq_reg;
    logic ackReq_next;
    logic unbalTrip_reg;
    logic unbalTrip_next;
    logic relayArmed_reg;
    logic relayArmed_next;
    logic extFault_reg;
    logic extFault_next;
    logic breakerTrip_reg;
    logic breakerTrip_next;
    logic run_reg;
    logic run_next;
    logic [7:0] thermal_reg;
    logic [7:0] thermal_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic relayEn_reg;
    logic relayEn_next;
    logic [2:0] tripCode;

    always_comb begin
        breakerProfile = (profileSelect >= sorc_pkg::PROF_MIN) && (profileSelect <= sorc_pkg::PROF_MAX);
        thHigh = atLeast(thermalImage, sorc_pkg::TH_TRIP);
        thLow = !atLeast(thermalImage, sorc_pkg::TH_RELEASE);

        // armed only by fresh enable each cycle
        relayArmed_next = relayArmed_reg;
        if (cycleTick) begin
            relayArmed_next = ctrl.relayEnable;
        end
        relayActive = relayArmed_reg && selectorAuto && breakerProfile;

        // starter stops at 110 with relay
        relayTrip_next = relayTrip_reg;
        if (relayActive && thHigh) begin
            relayTrip_next = 1'b1;
        // trip holds until image below 100
        end else if (thLow) begin
            relayTrip_next = 1'b0;
        end

        // ack request in manual at 110
        ackReq_next = ackReq_reg;
        if (ctrl.relayMode || modeRise) begin
            ackReq_next = 1'b0;
        end else if (relayActive && thHigh) begin
            // set wins over host acknowledge
            ackReq_next = 1'b1;
        end else if (runFall) begin
            ackReq_next = 1'b0;
        end

        remoteTrip_next = remoteTrip_reg;
        if (remoteTripRise && breakerProfile) begin
            remoteTrip_next = 1'b1;
        end else if (runFall) begin
            remoteTrip_next = 1'b0;
        end

        extFault_next = remoteTrip_next;
        // unresponsive starter hands trip to breaker
        breakerTrip_next = remoteTrip_reg && !starterStopped && !run_reg;
        if (!relayActive && thHigh) begin
            breakerTrip_next = 1'b1;
        end
        if (phaseUnbalance && atLeast(thermalImage, sorc_pkg::TH_RELEASE)) begin
            breakerTrip_next = 1'b1;
        end

        unbalTrip_next = unbalTrip_reg;
        if (phaseUnbalance && atLeast(thermalImage, sorc_pkg::TH_RELEASE)) begin
            unbalTrip_next = 1'b1;
        end else if (thLow) begin
            unbalTrip_next = 1'b0;
        end
        thermal_next = thermalImage;
        if (unbalTrip_reg && !thHigh) begin
            thermal_next = sorc_pkg::TH_TRIP;
        end

        // manual needs ack, auto restarts below 100
        // relay trip blocks run until below 100
        run_next = ctrl.runStop && !relayTrip_next && !remoteTrip_next && !ackReq_next;

        // relay in breaker off on fail or run
        relayEn_next = relayActive && breakerLinkOk && !run_next;

        // code 5 from 110; remote shown as 6
        if (remoteTrip_reg) begin
            tripCode = sorc_pkg::TRIP_REMOTE;
        end else if (relayTrip_reg || thHigh) begin
            tripCode = sorc_pkg::TRIP_RELAY;
        end else begin
            tripCode = sorc_pkg::TRIP_NONE;
        end
        status_next = sorc_pkg::BYTE_ZERO;
        status_next[sorc_pkg::TRIP_LSB +: 3] = tripCode;
        status_next[sorc_pkg::BIT_ACK] = ackReq_reg;

        // readback of the process image
        unique case (readOffset)
            sorc_pkg::OFF_HOST_CONTROL: rdata_next = sorc_pkg::BYTE_ZERO;
            sorc_pkg::OFF_STATUS_BYTE: rdata_next = status_reg;
            sorc_pkg::OFF_REL_CURRENT: rdata_next = relCur;
            sorc_pkg::OFF_THERMAL: rdata_next = thermal_reg;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            relayTrip_reg <= 1'b0;
            remoteTrip_reg <= 1'b0;
            ackReq_reg <= 1'b0;
            unbalTrip_reg <= 1'b0;
            relayArmed_reg <= 1'b0;
            extFault_reg <= 1'b0;
            breakerTrip_reg <= 1'b0;
            run_reg <= 1'b0;
            thermal_reg <= 8'h00;
            status_reg <= 8'h00;
            rdata_reg <= 8'h00;
            relayEn_reg <= 1'b0;
        end else begin
            relayTrip_reg <= relayTrip_next;
            remoteTrip_reg <= remoteTrip_next;
            ackReq_reg <= ackReq_next;
            unbalTrip_reg <= unbalTrip_next;
            relayArmed_reg <= relayArmed_next;
            extFault_reg <= extFault_next;
            breakerTrip_reg <= breakerTrip_next;
            run_reg <= run_next;
            thermal_reg <= thermal_next;
            status_reg <= status_next;
            rdata_reg <= rdata_next;
            relayEn_reg <= relayEn_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign readData = rdata_reg;
    assign statusByte = status_reg;
    assign relativeCurrent = relCur;
    assign thermalImageOut = thermal_reg;
    assign starterRun = run_reg;
    assign externalFault = extFault_reg;
    assign breakerTripReq = breakerTrip_reg;
    assign breakerRelayEnable = relayEn_reg;
endmodule
`default_nettype wire

//--- rtl/sorc_pkg.sv
// shared constants and carriers for the starter overload-relay control block
`default_nettype none
package sorc_pkg;
    // byte offsets of the cyclic process image
    localparam logic [1:0] OFF_HOST_CONTROL = 2'h0;
    localparam logic [1:0] OFF_STATUS_BYTE = 2'h1;
    localparam logic [1:0] OFF_REL_CURRENT = 2'h2;
    localparam logic [1:0] OFF_THERMAL = 2'h3;
    // control byte bit positions
    localparam int BIT_RUN = 0;
    localparam int BIT_RTRIP = 1;
    localparam int BIT_ZMR = 2;
    localparam int BIT_MODE = 3;
    // status byte fields
    localparam int BIT_ACK = 7;
    localparam int TRIP_LSB = 4;
    // thresholds in percent
    localparam logic [7:0] TH_TRIP = 8'h6e;
    localparam logic [7:0] TH_RELEASE = 8'h64;
    // trip indication codes
    localparam logic [2:0] TRIP_NONE = 3'h0;
    localparam logic [2:0] TRIP_RELAY = 3'h5;
    localparam logic [2:0] TRIP_REMOTE = 3'h6;
    // profile range holding the breaker
    localparam logic [3:0] PROF_MIN = 4'h1;
    localparam logic [3:0] PROF_MAX = 4'h9;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [7:0] PCT_MAX = 8'hff;

    typedef struct packed {
        logic relayMode;
        logic relayEnable;
        logic remoteTrip;
        logic runStop;
    } sorc_ctrl_t;

    typedef struct packed {
        logic [7:0] phaseA;
        logic [7:0] phaseB;
        logic [7:0] phaseC;
    } sorc_phase_t;
endpackage
`default_nettype wire

//--- rtl/sorc_rel_current.sv
// relative current: largest phase over release setting, in percent
`default_nettype none
module sorc_rel_current #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire sorc_pkg::sorc_phase_t phases,
    input wire logic [W-1:0] releaseSetting,
    output logic [7:0] relativeCurrent
);
    function automatic logic [W-1:0] maxOf(input logic [W-1:0] a, input logic [W-1:0] b);
        maxOf = (a > b) ? a : b;
    endfunction

    logic [W-1:0] peak;
    logic [W+7:0] quotient;
    logic [7:0] relativeCurrent_reg;
    logic [7:0] relativeCurrent_next;

    // ----------------------------------------
    // percent computation
    // ----------------------------------------
    always_comb begin
        peak = maxOf(maxOf(phases.phaseA, phases.phaseB), phases.phaseC);
        quotient = '0;
        if (releaseSetting != '0) begin
            quotient = ({8'h00, peak} * {8'h00, sorc_pkg::PCT_FULL}) / {8'h00, releaseSetting};
        end
        if (quotient > {{W{1'b0}}, sorc_pkg::PCT_MAX}) begin
            relativeCurrent_next = sorc_pkg::PCT_MAX;
        end else begin
            relativeCurrent_next = quotient[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            relativeCurrent_reg <= 8'h00;
        end else begin
            relativeCurrent_reg <= relativeCurrent_next;
        end
    end

    assign relativeCurrent = relativeCurrent_reg;
endmodule
`default_nettype wire

//--- rtl/sorc_ctrl_decode.sv
// control byte capture on each strobe and edge detection against the previously strobed byte
`default_nettype none
module sorc_ctrl_decode (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] hostControl,
    input wire logic hostStrobe,
    output sorc_pkg::sorc_ctrl_t ctrl,
    output logic remoteTripRise,
    output logic runFall,
    output logic modeRise,
    output logic cycleTick
);
    sorc_pkg::sorc_ctrl_t ctrl_reg;
    sorc_pkg::sorc_ctrl_t ctrl_next;
    logic [3:0] edges_reg;
    logic [3:0] edges_next;

    // ----------------------------------------
    // capture
    // ----------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        edges_next = 4'h0;
        if (hostStrobe) begin
            ctrl_next.runStop = hostControl[sorc_pkg::BIT_RUN];
            ctrl_next.remoteTrip = hostControl[sorc_pkg::BIT_RTRIP];
            ctrl_next.relayEnable = hostControl[sorc_pkg::BIT_ZMR];
            ctrl_next.relayMode = hostControl[sorc_pkg::BIT_MODE];
            edges_next[0] = ctrl_next.remoteTrip & ~ctrl_reg.remoteTrip;
            edges_next[1] = ~ctrl_next.runStop & ctrl_reg.runStop;
            edges_next[2] = ctrl_next.relayMode & ~ctrl_reg.relayMode;
            edges_next[3] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= '0;
            edges_reg <= 4'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            edges_reg <= edges_next;
        end
    end

    assign ctrl = ctrl_reg;
    assign remoteTripRise = edges_reg[0];
    assign runFall = edges_reg[1];
    assign modeRise = edges_reg[2];
    assign cycleTick = edges_reg[3];
endmodule
`default_nettype wire

//--- tb/sorc_assertions.sv
// assertions on the starter overload-relay control ports
`default_nettype none
module sorc_assertions (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] hostControl,
    input wire logic hostStrobe,
    input wire logic [3:0] profileSelect,
    input wire logic selectorAuto,
    input wire logic breakerLinkOk,
    input wire logic [7:0] thermalImage,
    input wire logic [7:0] statusByte,
    input wire logic starterRun,
    input wire logic externalFault,
    input wire logic breakerRelayEnable
);
    logic trip_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ----
    // last strobed trip bit
    // ----
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            trip_reg <= 1'b0;
        else if (hostStrobe)
            trip_reg <= hostControl[1];
    end
    // ----
    // properties
    // ----
    sequence s_trip;
        hostStrobe && hostControl[1:0] == 2'h3 && !trip_reg && profileSelect inside {[4'h1:4'h9]};
    endsequence
    // a remote trip overrides code 5, so it must stay away
    sequence s_hot;
        (thermalImage >= 8'h6e && !externalFault) [*3];
    endsequence
    property p_rtrip; s_trip |-> ##2 externalFault; endproperty
    a_rtrip: assert property (p_rtrip) else $error("remote trip missed");
    property p_stop; $rose(externalFault) |-> !starterRun; endproperty
    a_stop: assert property (p_stop) else $error("run kept on fault");
    property p_code6; externalFault ##1 externalFault |-> statusByte[6:4] == 3'h6; endproperty
    a_code6: assert property (p_code6) else $error("no code 6");
    property p_code5; s_hot |-> statusByte[6:4] == 3'h5; endproperty
    a_code5: assert property (p_code5) else $error("no code 5");
    property p_ack; hostStrobe && hostControl[3] |-> ##3 !statusByte[7]; endproperty
    a_ack: assert property (p_ack) else $error("ack kept in auto");
    property p_link; !breakerLinkOk [*3] |-> !breakerRelayEnable; endproperty
    a_link: assert property (p_link) else $error("relay on without link");
    property p_sel; !selectorAuto [*3] |-> !breakerRelayEnable; endproperty
    a_sel: assert property (p_sel) else $error("relay on in manual");
    property p_relStop; breakerRelayEnable && thermalImage >= 8'h6e |-> ##[1:4] !starterRun; endproperty
    a_relStop: assert property (p_relStop) else $error("no relay stop");
endmodule
bind sorc_top sorc_assertions chk (.core_clk, .rst_b, .hostControl, .hostStrobe, .profileSelect,
    .selectorAuto, .breakerLinkOk, .thermalImage, .statusByte, .starterRun, .externalFault, .breakerRelayEnable);
`default_nettype wire

//--- tb/sorc_host_model.sv
// host controller model: cyclic control byte refresh
`default_nettype none
module sorc_host_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] ctrlByte,
    output logic [7:0] hostControl,
    output logic hostStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ack is a run bit the bench clears
    always @(negedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hostStrobe <= 1'b0;
            hostControl <= 8'h00;
        end else begin
            hostStrobe <= !hostStrobe;
            // between strobes the bus never shows a stale copy
            hostControl <= hostStrobe ? ~hostControl : ctrlByte;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the starter overload-relay control block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic stuck = 1'b0;
    logic [7:0] ctrlByte = 8'h00;
    logic [7:0] hostControl;
    logic hostStrobe;
    logic [3:0] profileSelect = 4'h1;
    logic selectorAuto = 1'b1;
    logic breakerLinkOk = 1'b1;
    logic phaseUnbalance = 1'b0;
    logic [7:0] thermalImage = 8'h00;
    sorc_pkg::sorc_phase_t phaseCurrents = 24'h000000;
    logic [7:0] releaseSetting = 8'h64;
    logic [1:0] readOffset = 2'h0;
    logic starterStopped = 1'b1;
    logic [7:0] readData, statusByte, relativeCurrent, thermalImageOut;
    logic starterRun, externalFault, breakerTripReq, breakerRelayEnable;
    int miscompares = 0;
    int comparisons = 0;
    always #4 core_clk = ~core_clk;
    // power section follows run unless told to hang
    always @(negedge core_clk) starterStopped <= stuck ? 1'b0 : !starterRun;
    sorc_host_model host (.core_clk, .rst_b, .ctrlByte, .hostControl, .hostStrobe);
    sorc_top #(.CUR_W(8)) uut (.core_clk, .rst_b, .hostControl, .hostStrobe, .profileSelect, .selectorAuto,
        .breakerLinkOk, .phaseUnbalance, .thermalImage, .phaseCurrents, .releaseSetting, .readOffset,
        .starterStopped, .readData, .statusByte, .relativeCurrent, .thermalImageOut, .starterRun,
        .externalFault, .breakerTripReq, .breakerRelayEnable);
    // ----
    // tasks
    // ----
    task automatic chk(input logic [7:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // four strobes pass before the byte is judged
    task automatic send(input logic [7:0] b);
        ctrlByte <= b;
        settle(8);
    endtask
    task automatic waitRun(input logic v);
        for (int i = 0; i < 20 && starterRun !== v; i++) @(negedge core_clk);
        if (starterRun !== v) begin
            miscompares++;
            $display("CHECK FAILED t=%0t run wait timed out", $time);
            conclude();
        end
    endtask
    task automatic rd(input logic [1:0] o, input logic [7:0] e);
        readOffset <= o;
        settle(2);
        chk(readData, e, "read");
    endtask
    task automatic cur(input logic [23:0] p, input logic [7:0] s, e);
        phaseCurrents <= p;
        releaseSetting <= s;
        settle(3);
        chk(relativeCurrent, e, "current");
    endtask
    task automatic t_current;
        cur(24'h1e5a3c, 8'h3c, 8'h96);
        rd(2'h2, 8'h96);
        rd(2'h0, 8'h00);
        cur(24'h10c820, 8'h32, 8'hff);
        cur(24'h1e5a3c, 8'h00, 8'h00);
        $display("test current done");
    endtask
    task automatic t_remote;
        send(8'h01);
        waitRun(1'b1);
        send(8'h03);
        chk(8'(externalFault), 8'h01, "fault");
        chk(8'(starterRun), 8'h00, "run");
        chk(8'(breakerTripReq), 8'h00, "brk");
        rd(2'h1, 8'h60);
        send(8'h02);
        chk(statusByte, 8'h00, "cleared");
        send(8'h03);
        waitRun(1'b1);
        chk(8'(externalFault), 8'h00, "held bit");
        send(8'h01);
        profileSelect <= 4'ha;
        send(8'h03);
        chk(8'(externalFault), 8'h00, "profile");
        profileSelect <= 4'h1;
        send(8'h01);
        stuck <= 1'b1;
        send(8'h03);
        chk(8'(breakerTripReq), 8'h01, "hung");
        stuck <= 1'b0;
        send(8'h00);
        $display("test remote done");
    endtask
    task automatic t_relay;
        send(8'h04);
        chk(8'(breakerRelayEnable), 8'h01, "armed");
        breakerLinkOk <= 1'b0;
        settle(4);
        chk(8'(breakerRelayEnable), 8'h00, "link");
        breakerLinkOk <= 1'b1;
        selectorAuto <= 1'b0;
        settle(4);
        chk(8'(breakerRelayEnable), 8'h00, "selector");
        selectorAuto <= 1'b1;
        send(8'h00);
        chk(8'(breakerRelayEnable), 8'h00, "refresh");
        send(8'h05);
        waitRun(1'b1);
        thermalImage <= 8'h6e;
        waitRun(1'b0);
        settle(4);
        chk(statusByte, 8'hd0, "overload");
        thermalImage <= 8'h63;
        settle(4);
        chk(statusByte, 8'h80, "below 100");
        chk(8'(starterRun), 8'h00, "unacked");
        send(8'h04);
        chk(statusByte, 8'h00, "acked");
        send(8'h05);
        waitRun(1'b1);
        thermalImage <= 8'h6e;
        waitRun(1'b0);
        send(8'h0d);
        chk(statusByte, 8'h50, "auto");
        send(8'h09);
        chk(statusByte, 8'h50, "disabled mid-trip");
        chk(8'(starterRun), 8'h00, "held off");
        chk(8'(breakerTripReq), 8'h01, "no relay trip");
        thermalImage <= 8'h63;
        waitRun(1'b1);
        send(8'hfd);
        chk(8'(starterRun), 8'h01, "upper");
        phaseUnbalance <= 1'b1;
        thermalImage <= 8'h64;
        settle(6);
        chk(thermalImageOut, 8'h6e, "unbalance");
        chk(8'(breakerTripReq), 8'h01, "unbalance trip");
        rd(2'h3, 8'h6e);
        thermalImage <= 8'h50;
        phaseUnbalance <= 1'b0;
        settle(4);
        chk(thermalImageOut, 8'h50, "image");
        send(8'h00);
        $display("test relay done");
    endtask
    initial begin
        settle(6);
        rst_b <= 1'b1;
        @(negedge core_clk);
        chk(statusByte, 8'h00, "reset");
        t_current();
        t_remote();
        t_relay();
        conclude();
    end
endmodule
`default_nettype wire
